// file: src/tsync_port_status.sv
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
// Functional notes
// R1 - Slave with no sync for timeout intervals reports code 9
// R2 - Slave with grandmaster beyond plus or minus 100 ppm reports code 10
// R3 - Slave seeing sync interval outside supported range reports code 11
// R4 - Master without election seeing another master reports code 12
// R5 - Every statistic is a 64-bit unsigned counter
// R6 - All counters clear to zero at power-up and reset
// R7 - Direct mode counts both ways; tap mode reads transmit counters as zero
// R8 - Received sync counter steps once per received Sync
// R9 - Received announce counter steps once per received Announce
// R10 - Received peer-delay-request counter steps once per received Pdelay_Req
// R11 - Transmitted sync counter steps once per sent Sync
// R12 - Transmitted announce counter steps once per sent Announce
// R13 - Identifier and value lists share size and index; additions go last
// R14 - Counter reads are live per word, not one snapshot
// R15 - Status always holds one code; faults outrank in-progress codes
module tsync_port_status
    import tsync_pkg::*;
#(
    parameter int COUNT_W = 64
) (
    input  wire logic                      CLK,
    input  wire logic                      SRST,
    input  tsync_pkg::port_cond_t          PORT_COND,
    input  tsync_pkg::msg_events_t         MSG_EVENTS,
    input  wire logic [7:0]                RX_LOG_INTERVAL,
    input  wire logic [31:0]               GM_RATE_PPB,
    input  wire logic [7:0]                SYNC_TIMEOUT,
    input  wire logic                      SYNC_INTERVAL_TICK,
    input  wire logic [7:0]                ADDR,
    input  wire logic [31:0]               WDATA,
    input  wire logic                      WR,
    input  wire logic                      RD,
    output logic [31:0]                    RDATA,
    output tsync_pkg::sync_status_t        SYNC_STATUS
);

    import tsync_pkg::*;

    initial begin
        if (COUNT_W != CNT_W || COUNT_W < DATA_W + 1 || COUNT_W > 2 * DATA_W) begin
            $error("tsync_port_status: COUNT_W must be 64");
        end
    end

    // ========================================================
    // Declarations
    // ========================================================
    logic [COUNT_W-1:0]    cnt_value [NUM_CNT];
    logic [NUM_CNT-1:0]    cnt_inc;
    logic [NUM_CNT-1:0]    ev_vec;
    logic                  is_slave;
    logic                  is_tap;
    logic                  lone_master;
    logic [TOUT_W-1:0]     intervals_since_sync;
    logic                  sync_seen;
    logic                  timeout_flag;
    logic                  freq_flag;
    logic                  intv_flag;
    logic                  multi_flag;
    logic [7:0]            ctrl_min;
    logic [7:0]            ctrl_max;
    logic [31:0]           rate_mag;
    logic                  intv_bad;
    sync_status_t          next_status;
    logic [31:0]           next_rdata;
    logic [2:0]            cnt_sel;
    logic                  port_ready;

    assign is_slave    = (PORT_COND.state == PS_SLAVE);
    assign is_tap      = (PORT_COND.mode == MODE_TAP);
    assign lone_master = (PORT_COND.state == PS_MASTER) && !PORT_COND.bmca_en;
    assign ev_vec      = MSG_EVENTS;

    // Gate that every slave and master code sits behind
    assign port_ready  = PORT_COND.link_up && PORT_COND.proto_en && PORT_COND.as_capable && !PORT_COND.pdelay_high;

    // ========================================================
    // Message counters
    // ========================================================
    // Transmit traffic belongs to the tap partner in tap mode, so it is
    // neither counted nor shown here
    generate
        for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
            localparam bit IS_TX = (i >= FIRST_TX_IDX);
            assign cnt_inc[i] = ev_vec[i] && !(IS_TX && is_tap); // R7
            stat_counter #(
                .WIDTH (COUNT_W)
            ) u_cnt (
                .clk   (CLK),
                .srst  (SRST),
                .inc   (cnt_inc[i]), // R8 R9 R10 R11 R12
                .hide  (IS_TX && is_tap),
                .value (cnt_value[i])
            );
            // A counter hidden at the next edge reads zero, so it is exempt
            a_event_step: assert property (@(posedge CLK) disable iff (SRST) // R8 R9 R10 R11 R12
                cnt_inc[i] ##1 !(IS_TX && is_tap) |-> cnt_value[i] == $past(cnt_value[i]) + COUNT_W'(1))
                else $error("message count did not step");
        end
    endgenerate

    // ========================================================
    // Sync receipt timeout
    // ========================================================
    // Counts whole sync intervals since the last received Sync; saturates
    always_ff @(posedge CLK) begin
        if (SRST || !is_slave) begin
            intervals_since_sync <= '0;
        end else if (MSG_EVENTS.rx_sync) begin
            intervals_since_sync <= '0;
        end else if (SYNC_INTERVAL_TICK && intervals_since_sync != '1) begin
            intervals_since_sync <= intervals_since_sync + TOUT_W'(1);
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST || !is_slave) begin
            sync_seen <= 1'b0;
        end else if (MSG_EVENTS.rx_sync) begin
            sync_seen <= 1'b1;
        end
    end

    // A timeout of zero intervals would fault at once, so zero disables it
    assign timeout_flag = is_slave && (SYNC_TIMEOUT != 8'h00)
                          && (intervals_since_sync >= SYNC_TIMEOUT); // R1

    // ========================================================
    // Grandmaster frequency range
    // ========================================================
    assign rate_mag  = GM_RATE_PPB[31] ? (32'h0 - GM_RATE_PPB) : GM_RATE_PPB;
    assign freq_flag = is_slave && sync_seen && (rate_mag > FREQ_LIMIT_PPB); // R2

    // ========================================================
    // Sync interval range
    // ========================================================
    assign intv_bad = ($signed(RX_LOG_INTERVAL) < $signed(ctrl_min))
                      || ($signed(RX_LOG_INTERVAL) > $signed(ctrl_max));

    // Judged per received Sync and held until the next one
    always_ff @(posedge CLK) begin
        if (SRST || !is_slave) begin
            intv_flag <= 1'b0;
        end else if (MSG_EVENTS.rx_sync) begin
            intv_flag <= intv_bad; // R3
        end
    end

    // ========================================================
    // Multiple masters
    // ========================================================
    // Sticky while the lone-master setup lasts; any announce means a rival
    always_ff @(posedge CLK) begin
        if (SRST || !lone_master) begin
            multi_flag <= 1'b0;
        end else if (MSG_EVENTS.rx_announce || MSG_EVENTS.rx_sync) begin
            multi_flag <= 1'b1; // R4
        end
    end

    // ========================================================
    // Status code
    // ========================================================
    always_comb begin
        next_status = ST_MEAS_PDELAY;
        if (!PORT_COND.link_up) begin
            next_status = ST_LINK_DOWN;
        end else if (!PORT_COND.proto_en) begin
            next_status = ST_PROTO_OFF;
        end else if (!PORT_COND.as_capable) begin
            next_status = ST_PEER_INCAPABLE;
        end else if (PORT_COND.pdelay_high) begin
            next_status = ST_PDELAY_HIGH;
        end else if (is_slave) begin
            if (timeout_flag) begin
                next_status = ST_SYNC_TIMEOUT; // R1
            end else if (freq_flag) begin
                next_status = ST_FREQ_RANGE; // R2
            end else if (intv_flag) begin
                next_status = ST_INTV_RANGE; // R3
            end else if (!sync_seen) begin
                next_status = ST_WAIT_MASTER;
            end else if (!PORT_COND.servo_calibrated) begin
                next_status = ST_SYNCING;
            end else begin
                next_status = ST_SYNCED;
            end
        end else if (PORT_COND.state == PS_MASTER) begin
            if (multi_flag) begin
                next_status = ST_MULTI_MASTER; // R4
            end else if (PORT_COND.bmca_en && !PORT_COND.announce_settled) begin
                next_status = ST_MASTER_WAIT;
            end else begin
                next_status = ST_SYNCED;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            SYNC_STATUS <= ST_LINK_DOWN;
        end else begin
            SYNC_STATUS <= next_status; // R15
        end
    end

    // ========================================================
    // Control register
    // ========================================================
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ctrl_min <= CTRL_MIN_RST;
            ctrl_max <= CTRL_MAX_RST;
        end else if (WR && ADDR == REG_CTRL) begin
            ctrl_min <= WDATA[CTRL_MIN_LSB +: 8];
            ctrl_max <= WDATA[CTRL_MAX_LSB +: 8];
        end
    end

    // ========================================================
    // Read path
    // ========================================================
    // Each word is sampled on its own read, so a 64-bit value read as two
    // words may straddle an increment; software rereads the high word
    assign cnt_sel = ADDR[5:3];

    always_comb begin
        next_rdata = 32'h0;
        if (ADDR[1:0] == 2'h0) begin
            if (ADDR < REG_CNT_BASE + 8'(8 * NUM_CNT)) begin
                if (ADDR[2]) begin
                    next_rdata = cnt_value[cnt_sel][COUNT_W-1:DATA_W]; // R14
                end else begin
                    next_rdata = cnt_value[cnt_sel][DATA_W-1:0]; // R14
                end
            end else if (ADDR == REG_CNT_NUM) begin
                next_rdata = 32'(NUM_CNT); // R13
            end else if (ADDR >= REG_ID_BASE && ADDR < REG_ID_BASE + 8'(4 * NUM_CNT)) begin
                next_rdata = {24'h0, CNT_ID[3'((ADDR - REG_ID_BASE) >> 2)]}; // R13
            end else if (ADDR == REG_STATUS) begin
                next_rdata[STAT_CODE_LSB +: 4]  = SYNC_STATUS;
                next_rdata[STAT_STATE_LSB +: 2] = PORT_COND.state;
                next_rdata[STAT_TOUT_BIT]       = timeout_flag;
                next_rdata[STAT_FREQ_BIT]       = freq_flag;
                next_rdata[STAT_INTV_BIT]       = intv_flag;
                next_rdata[STAT_MULTI_BIT]      = multi_flag;
            end else if (ADDR == REG_CTRL) begin
                next_rdata[CTRL_MIN_LSB +: 8] = ctrl_min;
                next_rdata[CTRL_MAX_LSB +: 8] = ctrl_max;
            end
        end
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge CLK) begin
        if (SRST || !RD) begin
            RDATA <= 32'h0;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // ========================================================
    // Checks
    // ========================================================
    a_timeout_code: assert property (@(posedge CLK) disable iff (SRST) // R1
        (is_slave && PORT_COND.link_up && PORT_COND.proto_en && PORT_COND.as_capable
         && !PORT_COND.pdelay_high && timeout_flag) |=> SYNC_STATUS == ST_SYNC_TIMEOUT)
        else $error("sync timeout not reported as 9");

    a_freq_code: assert property (@(posedge CLK) disable iff (SRST) // R2
        (is_slave && PORT_COND.link_up && PORT_COND.proto_en && PORT_COND.as_capable
         && !PORT_COND.pdelay_high && !timeout_flag && freq_flag)
        |=> SYNC_STATUS == ST_FREQ_RANGE)
        else $error("frequency fault not reported as 10");

    a_interval_flag: assert property (@(posedge CLK) disable iff (SRST) // R3
        (is_slave && $past(is_slave) && MSG_EVENTS.rx_sync && intv_bad) |=> intv_flag)
        else $error("bad sync interval not flagged");

    a_multi_master: assert property (@(posedge CLK) disable iff (SRST) // R4
        (lone_master && MSG_EVENTS.rx_announce) ##1 lone_master
        |-> multi_flag)
        else $error("rival master not flagged");

    a_tap_tx_zero: assert property (@(posedge CLK) disable iff (SRST) // R7
        (is_tap && RD && ADDR == REG_CNT_BASE + 8'(8 * IDX_TX_SYNC)) ##1 is_tap
        |-> RDATA == 32'h0)
        else $error("tx counter visible in tap mode");

    a_rx_sync_count: assert property (@(posedge CLK) disable iff (SRST) // R8
        MSG_EVENTS.rx_sync |=> cnt_value[IDX_RX_SYNC] == $past(cnt_value[IDX_RX_SYNC]) + COUNT_W'(1))
        else $error("rx sync count did not step");

    a_tx_ann_count: assert property (@(posedge CLK) disable iff (SRST) // R12
        (MSG_EVENTS.tx_announce && !is_tap) ##1 !is_tap
        |-> cnt_value[IDX_TX_ANNOUNCE] == $past(cnt_value[IDX_TX_ANNOUNCE]) + COUNT_W'(1))
        else $error("tx announce count did not step");

    a_id_readback: assert property (@(posedge CLK) disable iff (SRST) // R13
        (RD && ADDR == REG_ID_BASE) |=> RDATA == {24'h0, CNT_ID[0]})
        else $error("first counter id misread");

    a_read_pulse: assert property (@(posedge CLK) disable iff (SRST)
        !$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside its cycle");

    a_reset_status: assert property (@(posedge CLK) // R6
        SRST |=> SYNC_STATUS == ST_LINK_DOWN && cnt_value[IDX_RX_ANNOUNCE] == '0)
        else $error("reset did not clear state");

    a_link_first: assert property (@(posedge CLK) disable iff (SRST) // R15
        !PORT_COND.link_up |=> SYNC_STATUS == ST_LINK_DOWN)
        else $error("link down not given precedence");

    // Codes follow their flags by one cycle
    a_interval_code: assert property (@(posedge CLK) disable iff (SRST) // R3
        (is_slave && port_ready && !timeout_flag && !freq_flag && intv_flag)
        |=> SYNC_STATUS == ST_INTV_RANGE)
        else $error("interval fault not reported as 11");

    a_multi_code: assert property (@(posedge CLK) disable iff (SRST) // R4
        (PORT_COND.state == PS_MASTER && port_ready && multi_flag)
        |=> SYNC_STATUS == ST_MULTI_MASTER)
        else $error("rival master not reported as 12");

    // A fresh Sync restarts the interval count
    a_sync_clears: assert property (@(posedge CLK) disable iff (SRST) // R1
        (is_slave && MSG_EVENTS.rx_sync)
        |=> !timeout_flag)
        else $error("timeout survived a Sync");

    // An interval fault implies a Sync was seen
    a_wait_code: assert property (@(posedge CLK) disable iff (SRST) // R15
        (is_slave && port_ready && !timeout_flag && !sync_seen)
        |=> SYNC_STATUS == ST_WAIT_MASTER)
        else $error("missing master not reported as 5");

endmodule

// file: inc/tsync_pkg.sv
package tsync_pkg;

    // ========================================================
    // Widths and counter list
    // ========================================================
    localparam int CNT_W   = 64;
    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 8;
    localparam int NUM_CNT = 5;
    localparam int TOUT_W  = 8;

    localparam int IDX_RX_SYNC     = 0;
    localparam int IDX_RX_ANNOUNCE = 1;
    localparam int IDX_RX_PDREQ    = 2;
    localparam int IDX_TX_SYNC     = 3;
    localparam int IDX_TX_ANNOUNCE = 4;
    localparam int FIRST_TX_IDX    = IDX_TX_SYNC;

    // Counter identifiers, same order as the value list; new ones go at the end
    localparam logic [7:0] CNT_ID [NUM_CNT] = '{8'h01, 8'h02, 8'h03, 8'h11, 8'h12};

    // ========================================================
    // Register map (byte addresses)
    // ========================================================
    localparam logic [ADDR_W-1:0] REG_CNT_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CNT_NUM  = 8'h40;
    localparam logic [ADDR_W-1:0] REG_ID_BASE  = 8'h44;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h60;
    localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h64;

    localparam int CTRL_MIN_LSB = 0;
    localparam int CTRL_MAX_LSB = 8;
    localparam logic [7:0] CTRL_MIN_RST = 8'hF8;
    localparam logic [7:0] CTRL_MAX_RST = 8'h03;

    localparam int STAT_CODE_LSB  = 0;
    localparam int STAT_STATE_LSB = 4;
    localparam int STAT_TOUT_BIT  = 8;
    localparam int STAT_FREQ_BIT  = 9;
    localparam int STAT_INTV_BIT  = 10;
    localparam int STAT_MULTI_BIT = 11;

    // ========================================================
    // Frequency limit of the grandmaster rate
    // ========================================================
    localparam int FREQ_LIMIT_PPM = 100;
    localparam logic [31:0] FREQ_LIMIT_PPB = 32'(FREQ_LIMIT_PPM * 1000);

    // ========================================================
    // Types
    // ========================================================
    typedef enum logic [3:0] {
        ST_SYNCED        = 4'h0,
        ST_LINK_DOWN     = 4'h1,
        ST_PROTO_OFF     = 4'h2,
        ST_MEAS_PDELAY   = 4'h3,
        ST_MASTER_WAIT   = 4'h4,
        ST_WAIT_MASTER   = 4'h5,
        ST_SYNCING       = 4'h6,
        ST_PEER_INCAPABLE= 4'h7,
        ST_PDELAY_HIGH   = 4'h8,
        ST_SYNC_TIMEOUT  = 4'h9,
        ST_FREQ_RANGE    = 4'hA,
        ST_INTV_RANGE    = 4'hB,
        ST_MULTI_MASTER  = 4'hC
    } sync_status_t;

    typedef enum logic [1:0] {
        PS_DISABLED = 2'h0,
        PS_MASTER   = 2'h1,
        PS_SLAVE    = 2'h2,
        PS_PASSIVE  = 2'h3
    } port_state_t;

    typedef enum logic {
        MODE_DIRECT = 1'b0,
        MODE_TAP    = 1'b1
    } port_mode_t;

    typedef struct packed {
        port_state_t state;
        logic        bmca_en;
        port_mode_t  mode;
        logic        link_up;
        logic        proto_en;
        logic        as_capable;
        logic        pdelay_high;
        logic        servo_calibrated;
        logic        announce_settled;
    } port_cond_t;

    // Field order puts rx_sync at bit 0 so bit i is counter index i
    typedef struct packed {
        logic tx_announce;
        logic tx_sync;
        logic rx_pdelay_req;
        logic rx_announce;
        logic rx_sync;
    } msg_events_t;

endpackage

// file: src/stat_counter.sv
`timescale 1ns/1ns
module stat_counter #(
    parameter int WIDTH = 64
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             inc,
    input  wire logic             hide,
    output logic [WIDTH-1:0]      value
);

    logic [WIDTH-1:0] cnt;

    initial begin
        if (WIDTH < 2) begin
            $error("stat_counter: WIDTH too small");
        end
    end

    // ========================================================
    // Counter
    // ========================================================
    // Plain wrap: at 64 bits a wrap never happens in service
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt <= '0; // R6
        end else if (inc) begin
            cnt <= cnt + WIDTH'(1); // R5
        end
    end

    assign value = hide ? '0 : cnt; // R7

    // ========================================================
    // Checks
    // ========================================================
    a_count_step: assert property (@(posedge clk) disable iff (srst) // R8
        inc |=> cnt == $past(cnt) + WIDTH'(1))
        else $error("counter did not step by one");

    a_count_hold: assert property (@(posedge clk) disable iff (srst)
        !inc |=> cnt == $past(cnt))
        else $error("counter moved without an event");

    a_reset_clear: assert property (@(posedge clk) // R6
        srst |=> cnt == '0)
        else $error("counter not cleared by reset");

    a_hidden_zero: assert property (@(posedge clk) disable iff (srst) // R7
        hide |-> value == '0 && !inc)
        else $error("hidden counter not idle");

endmodule

// file: testbench/net_peer.sv
`timescale 1ns/1ns
module net_peer (
    input  wire logic             clk,
    output tsync_pkg::msg_events_t events,
    output logic [7:0]            log_int
);
    import tsync_pkg::*;

    initial begin
        events  = '0;
        log_int = 8'h00;
    end

    // ========================================================
    // Message bursts: each high cycle is one message
    // ========================================================
    task automatic burst(input msg_events_t ev, input int n, input logic [7:0] li);
        @(posedge clk);
        events  <= ev;
        log_int <= li;
        repeat (n) @(posedge clk);
        events  <= '0;
        // Stale interval must not equal the one just sent
        log_int <= ~li;
    endtask
endmodule

// file: testbench/tsync_port_status_tb.sv
`timescale 1ns/1ns
module tsync_port_status_tb;
    import tsync_pkg::*;

    logic         clk;
    logic         srst;
    port_cond_t   cond;
    msg_events_t  events;
    logic [7:0]   log_int;
    logic [31:0]  rate;
    logic [7:0]   tout;
    logic         tick;
    logic [7:0]   addr;
    logic [31:0]  wdata;
    logic         wr;
    logic         rd;
    logic [31:0]  rdata;
    sync_status_t status;
    logic         tap;
    logic [31:0]  d;
    int           miscompares;
    int           cmp_count;
    logic [63:0]  cnt [NUM_CNT] = '{default: 64'h0};
    logic [7:0]   li_tab [4] = '{8'h04, 8'h03, 8'hF7, 8'hF8};
    sync_status_t ex_tab [4] = '{ST_INTV_RANGE, ST_SYNCED, ST_INTV_RANGE, ST_SYNCED};
    msg_events_t  ev_tab [5] = '{5'h09, 5'h12, 5'h04, 5'h1F, 5'h08};
    int           n_tab [5]  = '{3, 2, 4, 1, 5};

    tsync_port_status #(.COUNT_W(64)) dut (
        .CLK                (clk),
        .SRST               (srst),
        .PORT_COND          (cond),
        .MSG_EVENTS         (events),
        .RX_LOG_INTERVAL    (log_int),
        .GM_RATE_PPB        (rate),
        .SYNC_TIMEOUT       (tout),
        .SYNC_INTERVAL_TICK (tick),
        .ADDR               (addr),
        .WDATA              (wdata),
        .WR                 (wr),
        .RD                 (rd),
        .RDATA              (rdata),
        .SYNC_STATUS        (status)
    );

    net_peer peer (
        .clk     (clk),
        .events  (events),
        .log_int (log_int)
    );

    initial clk = 1'b0;
    always #25 clk = ~clk;

    // ========================================================
    // Bus and compare tasks
    // ========================================================
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr32(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd32(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        v = rdata;
    endtask

    // Two reads back to back; words are sampled one cycle apart
    task automatic rd64(input logic [7:0] a, output logic [63:0] q);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        addr <= a + 8'h04;
        #1;
        q[31:0] = rdata;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        q[63:32] = rdata;
    endtask

    task automatic chk_st(input sync_status_t exp);
        logic [31:0] v;
        repeat (3) @(posedge clk);
        #1;
        chk("status", {60'h0, exp}, {60'h0, status});
        rd32(REG_STATUS, v);
        chk("status reg", {60'h0, exp}, {60'h0, v[3:0]});
        chk("flags", exp < ST_SYNC_TIMEOUT ? 64'h0 : 64'h1 << (exp - ST_SYNC_TIMEOUT), 64'(v[11:8]));
    endtask

    task automatic check_counters();
        logic [63:0] q;
        for (int i = 0; i < NUM_CNT; i++) begin
            rd64(8'(8 * i), q);
            chk("counter", (tap && i >= FIRST_TX_IDX) ? 64'h0 : cnt[i], q);
        end
    endtask

    task automatic send(input msg_events_t ev, input int n);
        peer.burst(ev, n, 8'h00);
        for (int b = 0; b < NUM_CNT; b++) begin
            if (ev[b] && !(tap && b >= FIRST_TX_IDX)) begin
                cnt[b] += 64'(n);
            end
        end
    endtask

    task automatic tick_n(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("[FAIL] run length expected end seen hang");
        stop_test();
    end

    // ========================================================
    // Main sequence
    // ========================================================
    initial begin
        srst = 1'b1;
        cond = '0;
        rate = 32'h0;
        tout = 8'h02;
        tick = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        tap = 1'b0;
        miscompares = 0;
        cmp_count = 0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        cond.link_up <= 1'b1;
        cond.proto_en <= 1'b1;
        cond.as_capable <= 1'b1;
        cond.bmca_en <= 1'b1;
        cond.state <= PS_SLAVE;
        chk_st(ST_WAIT_MASTER);
        tick_n(1);
        chk_st(ST_WAIT_MASTER);
        tick_n(1);
        chk_st(ST_SYNC_TIMEOUT);
        tout <= 8'h00;
        chk_st(ST_WAIT_MASTER);
        tout <= 8'h02;
        peer.burst(5'h01, 1, 8'h00);
        chk_st(ST_SYNCING);
        cond.servo_calibrated <= 1'b1;
        chk_st(ST_SYNCED);
        rate <= 32'h000186A0;
        chk_st(ST_SYNCED);
        rate <= 32'h000186A1;
        chk_st(ST_FREQ_RANGE);
        rate <= 32'hFFFE795F;
        chk_st(ST_FREQ_RANGE);
        rate <= 32'h0;
        for (int k = 0; k < 4; k++) begin
            peer.burst(5'h01, 1, li_tab[k]);
            chk_st(ex_tab[k]);
        end
        rd32(REG_CTRL, d);
        chk("ctrl", 64'h3F8, 64'(d));
        wr32(REG_CTRL, 32'h000000F8);
        peer.burst(5'h01, 1, 8'h01);
        chk_st(ST_INTV_RANGE);
        peer.burst(5'h01, 1, 8'h00);
        chk_st(ST_SYNCED);
        cond.state <= PS_MASTER;
        cond.bmca_en <= 1'b0;
        chk_st(ST_SYNCED);
        peer.burst(5'h02, 1, 8'h00);
        chk_st(ST_MULTI_MASTER);
        cond.bmca_en <= 1'b1;
        chk_st(ST_MASTER_WAIT);
        cond.announce_settled <= 1'b1;
        chk_st(ST_SYNCED);
        cond.link_up <= 1'b0;
        cond.proto_en <= 1'b0;
        cond.as_capable <= 1'b0;
        cond.pdelay_high <= 1'b1;
        chk_st(ST_LINK_DOWN);
        cond.link_up <= 1'b1;
        chk_st(ST_PROTO_OFF);
        cond.proto_en <= 1'b1;
        chk_st(ST_PEER_INCAPABLE);
        cond.as_capable <= 1'b1;
        chk_st(ST_PDELAY_HIGH);
        cond.pdelay_high <= 1'b0;
        cond.state <= PS_PASSIVE;
        chk_st(ST_MEAS_PDELAY);
        wr32(REG_CNT_NUM, 32'h00000077);
        rd32(REG_CNT_NUM, d);
        chk("count reg", 64'h5, 64'(d));
        rd32(8'h80, d);
        chk("unmapped", 64'h0, 64'(d));
        rd32(8'h41, d);
        chk("unaligned", 64'h0, 64'(d));
        @(posedge clk);
        #1;
        chk("rdata idle", 64'h0, 64'(rdata));
        for (int i = 0; i < NUM_CNT; i++) begin
            rd32(REG_ID_BASE + 8'(4 * i), d);
            chk("id", 64'(CNT_ID[i]), 64'(d));
        end
        // Reset in mid-run after traffic was counted
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("reset status", {60'h0, ST_LINK_DOWN}, {60'h0, status});
        @(posedge clk);
        srst <= 1'b0;
        check_counters();
        for (int k = 0; k < 5; k++) send(ev_tab[k], n_tab[k]);
        check_counters();
        cond.mode <= MODE_TAP;
        tap = 1'b1;
        for (int k = 0; k < 5; k++) send(ev_tab[k], n_tab[k]);
        check_counters();
        cond.mode <= MODE_DIRECT;
        tap = 1'b0;
        check_counters();
        send(5'h18, 2);
        check_counters();
        stop_test();
    end
endmodule
